// *** include/ppt_pkg.sv ***
// Package with addresses, field layout, commands and reset values of the parallel port and timer unit.
package ppt_pkg;

  // I/O addresses decoded by the unit.
  localparam logic [7:0] ADDR_CMD_STATUS  = 8'hE8;
  localparam logic [7:0] ADDR_OUT_PORT    = 8'hE9;
  localparam logic [7:0] ADDR_IN_PORT8    = 8'hEA;
  localparam logic [7:0] ADDR_IN_PORT6    = 8'hEB;
  localparam logic [7:0] ADDR_TMR_LOW     = 8'hEC;
  localparam logic [7:0] ADDR_TMR_HIGH    = 8'hED;

  // Widths of the counter, its fields and the six-bit input port.
  localparam int         CNT_W            = 14;
  localparam int         HI_CNT_W         = 6;
  localparam int         IN6_W            = 6;

  // Command and status register field positions.
  localparam int         CMD_TMR_LSB      = 6;
  localparam int         CMD_PORT_MSB     = 5;
  localparam int         STAT_TMR_BIT     = 6;

  // Timer control command encodings.
  localparam logic [1:0] TCMD_NOP         = 2'h0;
  localparam logic [1:0] TCMD_STOP_NOW    = 2'h1;
  localparam logic [1:0] TCMD_STOP_AT_TC  = 2'h2;
  localparam logic [1:0] TCMD_START       = 2'h3;

  // Output mode encodings.
  localparam logic [1:0] MODE_HALF_LOW    = 2'h0;
  localparam logic [1:0] MODE_SQUARE      = 2'h1;
  localparam logic [1:0] MODE_PULSE_ONCE  = 2'h2;
  localparam logic [1:0] MODE_PULSE_RELD  = 2'h3;

  // Reset values and small constants.
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
  localparam logic [13:0] CNT_ZERO        = 14'h0000;
  localparam logic [13:0] CNT_ONE         = 14'h0001;
  localparam logic [13:0] CNT_TWO         = 14'h0002;
  localparam logic [1:0]  MODE_RESET      = 2'h0;

  // Timer input rate and nominal bit-rate counts for software use.
  localparam int         TMR_IN_HZ        = 1228800;
  localparam int         CNT_4800_BAUD    = 256;
  localparam int         CNT_110_BAUD     = 11171;

  typedef enum logic [1:0] {
    PPT_TMR_IDLE,
    PPT_TMR_RUN,
    PPT_TMR_LAST
  } ppt_tmr_state_e;

endpackage

// *** rtl/ppt_sync.sv ***
// Three-stage synchroniser that accepts a change once the second and third stages agree.
`timescale 1ns/100ps
module ppt_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  // Asynchronous level in, filtered level out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  wire  [W-1:0] agree_mask = ~(s2_q ^ s3_q);

  // Shift chain; each output bit updates only when the two late stages agree.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= (s3_q & agree_mask) | (out_q & ~agree_mask);
    end
  end

  assign sync_out = out_q;

endmodule

// *** rtl/ppt_top.sv ***
// Parallel I/O ports and 14-bit interval timer reached by host I/O reads and writes.
// Overview of operation
// RL1: Write to output port address latches the byte onto the output pins.
// RL2: Reading the output port address returns the last written byte.
// RL3: The two input port addresses return live levels of the 8-bit and 6-bit ports.
// RL4: Timer is a 14-bit down counter, one step per timer input pulse, detecting terminal count.
// RL5: At terminal count the output gives a square wave or pulse per mode.
// RL6: Software loads 256 for 4800 baud up to 11171 for 110 baud.
// RL7: Low timer address holds low count byte; high address holds high bits and mode.
// RL8: Timer writes load a 16-bit length register: count in 0-13, mode in 14-15.
// RL9: Timer reads return the live count plus mode bits, not the loaded length.
// RL10: Software should stop the counter before reading, then reload and restart.
// RL11: Mode 00 drives output low in second half; odd counts stay high longer.
// RL12: Mode 01 gives a square wave of period equal to count, auto reload.
// RL13: Mode 10 emits one pulse at terminal count and stops without reload.
// RL14: Mode 11 reloads automatically and pulses at every terminal count.
// RL15: Software stops the counter, then writes the length register byte by byte.
// RL16: Repetitive mode keeps reloading and pulsing until a command stops it.
// RL17: Command bits 6-7 start and stop; new length applies to the next count.
// RL18: Timer output is offered as the CPU's highest-priority interrupt request.
// RL19: The command register is written at its own address at any time.
// RL20: Status is readable any time; bit 6 reports the timer status.
// RL21: Timer commands: 00 none, 01 stop now, 10 stop after TC, 11 start.
`timescale 1ns/100ps
module ppt_top
  import ppt_pkg::*;
(
  // Clock and reset.
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  // Host I/O cycle.
  input  wire logic [7:0]         io_addr_in,
  input  wire logic [7:0]         io_wdata_in,
  input  wire logic               io_wr_in,
  input  wire logic               io_rd_in,
  output logic      [7:0]         io_rdata_out,
  // Parallel ports.
  output logic      [7:0]         automatic_calling_unit_out,
  input  wire logic [7:0]         in_port8_in,
  input  wire logic [IN6_W-1:0]   in_port6_in,
  // Timer input and output.
  input  wire logic               timer_clk_in,
  output logic                    timer_out,
  output logic                    timer_interrupt_out,
  // Command bits for port setup kept outside the timer.
  output logic      [5:0]         port_cmd_out
);
  import ppt_pkg::*;

  // Synchronised pins.
  logic [7:0]       in8_s;
  logic [IN6_W-1:0] in6_s;
  logic             tin_s;

  ppt_sync #(.W(8 + IN6_W + 1)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({in_port8_in, in_port6_in, timer_clk_in}),
    .sync_out   ({in8_s, in6_s, tin_s})
  );

  // Registers.
  logic [7:0]       out_port_q;
  logic [5:0]       port_cmd_q;
  logic [CNT_W-1:0] len_q;
  logic [1:0]       len_mode_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [1:0]       mode_q;
  logic             tin_prev_q;
  logic             out_q;
  logic             out_d;
  logic             tc_seen_q;
  logic             stop_at_tc_q;
  logic             stop_at_tc_d;
  ppt_tmr_state_e   st_q;
  ppt_tmr_state_e   st_d;
  logic             tc_seen_d;

  // Returns true when the count is in its second (low) half.
  function automatic logic in_low_half(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] len);
    logic [CNT_W-1:0] half;
    half = len >> 1;
    in_low_half = (cnt <= half);
  endfunction

  // Address decode and strobes.
  wire wr_cmd   = io_wr_in && (io_addr_in == ADDR_CMD_STATUS);
  wire wr_out   = io_wr_in && (io_addr_in == ADDR_OUT_PORT);
  wire wr_tlow  = io_wr_in && (io_addr_in == ADDR_TMR_LOW);
  wire wr_thigh = io_wr_in && (io_addr_in == ADDR_TMR_HIGH);
  wire [1:0] tcmd = wr_cmd ? io_wdata_in[CMD_TMR_LSB +: 2] : TCMD_NOP;
  wire pulse    = tin_s && !tin_prev_q;
  wire running  = (st_q != PPT_TMR_IDLE);
  wire at_tc    = running && pulse && (cnt_q <= CNT_ONE);
  wire cont     = (mode_q == MODE_SQUARE) || (mode_q == MODE_PULSE_RELD);

  // Read data selection.
  wire [7:0] rd_mux =
    (io_addr_in == ADDR_CMD_STATUS) ? {1'b0, tc_seen_q, BYTE_ZERO[5:0]} :
    (io_addr_in == ADDR_OUT_PORT)   ? out_port_q :
    (io_addr_in == ADDR_IN_PORT8)   ? in8_s :
    (io_addr_in == ADDR_IN_PORT6)   ? {2'b00, in6_s} :
    (io_addr_in == ADDR_TMR_LOW)    ? cnt_q[7:0] :
    (io_addr_in == ADDR_TMR_HIGH)   ? {mode_q, cnt_q[CNT_W-1:8]} : BYTE_ZERO;

  // Port, command and length registers written by the host.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      out_port_q   <= BYTE_ZERO;
      port_cmd_q   <= BYTE_ZERO[5:0];
      len_q        <= CNT_ZERO;
      len_mode_q   <= MODE_RESET;
      io_rdata_out <= BYTE_ZERO;
      tin_prev_q   <= 1'b0;
    end else begin
      tin_prev_q <= tin_s;
      if (wr_out) begin
        out_port_q <= io_wdata_in; // RL1
      end
      if (wr_cmd) begin
        port_cmd_q <= io_wdata_in[CMD_PORT_MSB:0]; // RL19
      end
      if (wr_tlow) begin
        len_q[7:0] <= io_wdata_in; // RL7 RL8
      end
      if (wr_thigh) begin
        len_q[CNT_W-1:8] <= io_wdata_in[HI_CNT_W-1:0]; // RL7 RL8
        len_mode_q       <= io_wdata_in[7:6]; // RL8
      end
      if (io_rd_in) begin
        io_rdata_out <= rd_mux; // RL2 RL3 RL9 RL20
      end
    end
  end

  // Timer next-state logic.
  always_comb begin
    st_d         = st_q;
    cnt_d        = cnt_q;
    out_d        = out_q;
    stop_at_tc_d = stop_at_tc_q;
    tc_seen_d    = tc_seen_q;
    case (st_q)
      PPT_TMR_IDLE: begin
        out_d = 1'b1;
        if (tcmd == TCMD_START) begin // RL21
          cnt_d        = len_q; // RL17
          st_d         = PPT_TMR_RUN;
          stop_at_tc_d = 1'b0;
        end
      end
      PPT_TMR_RUN, PPT_TMR_LAST: begin
        if (pulse) begin
          cnt_d = cnt_q - CNT_ONE; // RL4
        end
        if (at_tc) begin
          tc_seen_d = 1'b1;
          if (cont && !stop_at_tc_q) begin
            cnt_d = len_q; // RL12 RL14 RL16
          end else begin
            st_d = PPT_TMR_IDLE; // RL13
          end
        end
        // In modes 00 and 01 the level follows the count held next, so a reload at terminal count starts the high half.
        if (pulse) begin
          if (mode_q == MODE_PULSE_ONCE || mode_q == MODE_PULSE_RELD) begin
            out_d = !at_tc; // RL5
          end else begin
            out_d = !in_low_half(cnt_d, len_q); // RL11 RL12
          end
        end
        // A stop request in the cycle that already ends the count must not revive the timer.
        if (tcmd == TCMD_STOP_NOW) begin // RL21
          st_d = PPT_TMR_IDLE;
        end else if (tcmd == TCMD_STOP_AT_TC && st_d != PPT_TMR_IDLE) begin // RL21
          stop_at_tc_d = 1'b1;
          st_d         = PPT_TMR_LAST;
        end
      end
      default: begin
        st_d = PPT_TMR_IDLE;
      end
    endcase
    if (io_rd_in && io_addr_in == ADDR_CMD_STATUS) begin
      tc_seen_d = at_tc; // RL20
    end
  end

  // Timer state registers.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_q         <= PPT_TMR_IDLE;
      cnt_q        <= CNT_ZERO;
      mode_q       <= MODE_RESET;
      out_q        <= 1'b1;
      stop_at_tc_q <= 1'b0;
      tc_seen_q    <= 1'b0;
    end else begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      out_q        <= out_d;
      stop_at_tc_q <= stop_at_tc_d;
      tc_seen_q    <= tc_seen_d;
      if (st_q == PPT_TMR_IDLE && tcmd == TCMD_START) begin
        mode_q <= len_mode_q; // RL21
      end
    end
  end

  // Outputs.
  assign automatic_calling_unit_out = out_port_q; // RL1
  assign timer_out                  = out_q;
  assign timer_interrupt_out        = out_q; // RL18
  assign port_cmd_out               = port_cmd_q;

  // Assertions.
  a_out_port_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL1
    wr_out |=> automatic_calling_unit_out == $past(io_wdata_in))
    else $error("Output port did not take written byte.");

  a_tc_single_stop: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL13
    (at_tc && mode_q == MODE_PULSE_ONCE && tcmd != TCMD_START) |=> st_q == PPT_TMR_IDLE)
    else $error("Single pulse mode kept running after terminal count.");

  a_tc_reload_cnt: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL14
    (at_tc && mode_q == MODE_PULSE_RELD && !stop_at_tc_q && tcmd == TCMD_NOP) |=> cnt_q == $past(len_q))
    else $error("Reload mode did not reload at terminal count.");

  a_tc_pulse_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL5
    (at_tc && mode_q[1]) |=> !timer_out)
    else $error("No pulse at terminal count.");

  a_count_decrement: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL4
    (running && pulse && !at_tc && tcmd == TCMD_NOP) |=> cnt_q == $past(cnt_q) - CNT_ONE)
    else $error("Counter did not step down on timer pulse.");

  a_stop_now: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL21
    (running && tcmd == TCMD_STOP_NOW) |=> st_q == PPT_TMR_IDLE ##1 st_q == PPT_TMR_IDLE || $past(tcmd) == TCMD_START)
    else $error("Stop command did not halt the timer.");

  a_start_load: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL17
    (!running && tcmd == TCMD_START) |=> (cnt_q == $past(len_q) && mode_q == $past(len_mode_q)))
    else $error("Start did not load count length and mode.");

  a_timer_readback: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL9
    (io_rd_in && io_addr_in == ADDR_TMR_HIGH) |=> io_rdata_out == {$past(mode_q), $past(cnt_q[CNT_W-1:8])})
    else $error("Timer read did not return live count and mode.");

  // Register bus read-back and write paths.
  a_rd_out_port: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL2
    (io_rd_in && io_addr_in == ADDR_OUT_PORT) |=> io_rdata_out == $past(out_port_q))
    else $error("Output port read did not return the latched byte.");

  a_rd_in_port8: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL3
    (io_rd_in && io_addr_in == ADDR_IN_PORT8) |=> io_rdata_out == $past(in8_s))
    else $error("Eight-bit input port read returned a wrong level.");

  a_rd_in_port6: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL3
    (io_rd_in && io_addr_in == ADDR_IN_PORT6) |=> io_rdata_out == {2'b00, $past(in6_s)})
    else $error("Six-bit input port read returned a wrong level.");

  a_rd_timer_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL9
    (io_rd_in && io_addr_in == ADDR_TMR_LOW) |=> io_rdata_out == $past(cnt_q[7:0]))
    else $error("Timer low read did not return the live count.");

  a_len_low_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL7
    wr_tlow |=> len_q[7:0] == $past(io_wdata_in))
    else $error("Low count byte was not loaded.");

  a_len_high_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL8
    wr_thigh |=> (len_q[CNT_W-1:8] == $past(io_wdata_in[HI_CNT_W-1:0]) && len_mode_q == $past(io_wdata_in[7:6])))
    else $error("High count bits or mode were not loaded.");

  a_cmd_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL19
    wr_cmd |=> port_cmd_out == $past(io_wdata_in[CMD_PORT_MSB:0]))
    else $error("Command port bits were not loaded.");

  a_status_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL20
    (io_rd_in && io_addr_in == ADDR_CMD_STATUS) |=> io_rdata_out == {1'b0, $past(tc_seen_q), BYTE_ZERO[5:0]})
    else $error("Status read did not report the timer flag.");

  // Timer flag, output level and stop behaviour.
  a_tc_sets_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL20
    at_tc |=> tc_seen_q)
    else $error("Terminal count did not set the status flag.");

  a_idle_irq_high: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL18
    !running |=> timer_interrupt_out)
    else $error("Interrupt output not high while the timer is stopped.");

  a_square_reload: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL12
    (at_tc && mode_q == MODE_SQUARE && !stop_at_tc_q && tcmd == TCMD_NOP && len_q != CNT_ZERO)
      |=> (cnt_q == $past(len_q) && timer_out))
    else $error("Square wave did not reload into its high half.");

  a_half_low_level: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL11
    (running && pulse && !at_tc && !mode_q[1] && tcmd == TCMD_NOP) |=> timer_out == (cnt_q > ($past(len_q) >> 1)))
    else $error("Output level does not match the half of the count.");

  a_stop_at_tc: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL16
    (at_tc && stop_at_tc_q && tcmd == TCMD_NOP) |=> !running)
    else $error("Timer kept running after a stop at terminal count.");

endmodule

// *** test/ppt_host_model.sv ***
// Host CPU model that issues I/O write and read cycles to the port and timer unit.
`timescale 1ns/100ps
module ppt_host_model
  import ppt_pkg::*;
(
  // Clock.
  input  wire logic       sys_clk_in,
  // I/O cycle towards the unit.
  output logic      [7:0] io_addr_out,
  output logic      [7:0] io_wdata_out,
  output logic            io_wr_out,
  output logic            io_rd_out,
  input  wire logic [7:0] io_rdata_in
);
  import ppt_pkg::*;

  // Idle bus at time zero.
  initial begin
    io_addr_out = 8'h00;
    io_wdata_out = 8'h00;
    io_wr_out = 1'b0;
    io_rd_out = 1'b0;
  end

  // One-cycle write strobe, taken at the following rising edge.
  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    io_addr_out = a;
    io_wdata_out = d;
    io_wr_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    io_wr_out = 1'b0;
    io_wdata_out = ~d;
  endtask

  // One-cycle read strobe; the data is registered at the edge that takes it.
  task automatic io_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    io_addr_out = a;
    io_rd_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    io_rd_out = 1'b0;
    d = io_rdata_in;
  endtask

  // Stops the counter first, then loads the length one byte at a time.
  task automatic load_timer(input logic [13:0] len, input logic [1:0] mode);
    io_write(ADDR_CMD_STATUS, 8'h40);
    io_write(ADDR_TMR_LOW, len[7:0]);
    io_write(ADDR_TMR_HIGH, {mode, len[13:8]});
  endtask
endmodule

// *** test/test_parallel_port_and_interval_timer.sv ***
// Self-checking testbench for the parallel port and interval timer unit.
`timescale 1ns/100ps
module test_parallel_port_and_interval_timer;
  import ppt_pkg::*;

  logic       sys_clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [7:0] io_addr, io_wdata, io_rdata, automatic_calling_unit, in8;
  logic       io_wr, io_rd, tclk, tout, tint;
  logic [5:0] in6, pcmd;
  int         num_errors = 0;
  int         total_checks = 0;
  int         falls = 0;
  int         lo = 0;
  logic       prev = 1'b1;

  // The clock toggles every half period of 2.5 ns.
  always #2.5 sys_clk_in = ~sys_clk_in;

  ppt_host_model host (.sys_clk_in(sys_clk_in), .io_addr_out(io_addr), .io_wdata_out(io_wdata),
    .io_wr_out(io_wr), .io_rd_out(io_rd), .io_rdata_in(io_rdata));

  ppt_top dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr), .io_wdata_in(io_wdata),
    .io_wr_in(io_wr), .io_rd_in(io_rd), .io_rdata_out(io_rdata), .automatic_calling_unit_out(automatic_calling_unit),
    .in_port8_in(in8), .in_port6_in(in6), .timer_clk_in(tclk), .timer_out(tout),
    .timer_interrupt_out(tint), .port_cmd_out(pcmd));

  // Counts output pulses and low cycles, and watches the interrupt copy.
  always @(posedge sys_clk_in) begin
    if (prev === 1'b1 && tout === 1'b0) falls++;
    if (tout === 1'b0) lo++;
    if (rst_n_in && tint !== tout) begin
      num_errors++;
      $display("[FAIL] t=%0t interrupt=%h timer=%h", $time, tint, tout);
    end
    prev = tout;
  end

  // Compares a seen value against the expected one.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Reads an address and compares the returned byte.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.io_read(a, v);
    check({8'h00, v}, {8'h00, exp});
  endtask

  // Gives n timer input periods of eight system clocks each, then lets the last edge reach the output.
  task automatic tick(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk_in);
      #1 tclk = 1'b1;
      repeat (4) @(posedge sys_clk_in);
      #1 tclk = 1'b0;
    end
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask

  // Starts the counter and clears the pulse counters.
  task automatic start;
    host.io_write(ADDR_CMD_STATUS, 8'hC0);
    falls = 0;
    lo = 0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #400000;
    num_errors++;
    test_done();
  end

  // Main sequence.
  initial begin
    tclk = 1'b0;
    in8 = 8'h3C;
    in6 = 6'h2A;
    repeat (20) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    check({8'h00, automatic_calling_unit}, 16'h0000);
    check({15'h0, tout}, 16'h0001);
    check({10'h0, pcmd}, 16'h0000);
    host.io_write(ADDR_OUT_PORT, 8'hA5);
    check({8'h00, automatic_calling_unit}, 16'h00A5);
    rd_chk(ADDR_OUT_PORT, 8'hA5);
    host.io_write(ADDR_CMD_STATUS, 8'h15);
    check({10'h0, pcmd}, 16'h0015);
    rd_chk(ADDR_IN_PORT8, 8'h3C);
    rd_chk(ADDR_IN_PORT6, 8'h2A);
    rd_chk(8'h00, 8'h00);
    // Single pulse, no reload.
    host.load_timer(14'd3, MODE_PULSE_ONCE);
    start();
    rd_chk(ADDR_TMR_LOW, 8'h03);
    rd_chk(ADDR_TMR_HIGH, 8'h80);
    tick(1);
    rd_chk(ADDR_TMR_LOW, 8'h02);
    tick(2);
    check(16'(falls), 16'h0001);
    rd_chk(ADDR_CMD_STATUS, 8'h40);
    rd_chk(ADDR_CMD_STATUS, 8'h00);
    tick(3);
    check(16'(falls), 16'h0001);
    check({15'h0, tout}, 16'h0001);
    // Repetitive pulses, then stop after the next terminal count.
    host.load_timer(14'd2, MODE_PULSE_RELD);
    start();
    tick(6);
    check(16'(falls), 16'h0003);
    host.io_write(ADDR_CMD_STATUS, 8'h80);
    tick(4);
    check(16'(falls), 16'h0004);
    // Immediate stop in mid-count.
    start();
    tick(1);
    host.io_write(ADDR_CMD_STATUS, 8'h40);
    falls = 0;
    tick(4);
    check(16'(falls), 16'h0000);
    // Square wave with an even length.
    host.load_timer(14'd4, MODE_SQUARE);
    start();
    tick(8);
    check(16'(falls), 16'h0002);
    check(16'(lo > 24 && lo < 40), 16'h0001);
    // Low for the smaller half with an odd length.
    host.load_timer(14'd5, MODE_HALF_LOW);
    start();
    tick(10);
    check(16'(falls), 16'h0001);
    check(16'(lo > 16 && lo < 24), 16'h0001);
    // Bit-rate count readback.
    host.load_timer(14'(CNT_4800_BAUD), MODE_PULSE_RELD);
    start();
    rd_chk(ADDR_TMR_LOW, 8'h00);
    rd_chk(ADDR_TMR_HIGH, 8'hC1);
    host.io_write(ADDR_CMD_STATUS, 8'h40);
    test_done();
  end
endmodule
